// [src/kpi_pkg.sv]
// package of register map and field constants for the keypad pin interrupt
package kpi_pkg;
	// ****************************************
	// register map (word addresses, byte address = 4 * index)
	// ****************************************
	localparam logic [3:0] KPI_IDX_SC = 4'h0;
	localparam logic [3:0] KPI_IDX_PE = 4'h1;
	localparam logic [3:0] KPI_IDX_ES = 4'h2;
	localparam logic [3:0] KPI_IDX_PULL = 4'h3;
	localparam logic [3:0] KPI_IDX_IST = 4'h4;
	localparam logic [3:0] KPI_IDX_ICLR = 4'h5;
	localparam logic [3:0] KPI_IDX_IEN = 4'h6;
	// ****************************************
	// control register fields
	// ****************************************
	localparam int KPI_SC_MODE = 0;
	localparam int KPI_SC_IE = 1;
	localparam int KPI_SC_ACK = 2;
	localparam int KPI_SC_FLAG = 3;
	// ****************************************
	// event bits of the interrupt status register
	// ****************************************
	localparam int KPI_EV_DETECT = 0;
	localparam int KPI_EV_ACKFAIL = 1;
	localparam int KPI_NEV = 2;
	localparam logic [7:0] KPI_RST8 = 8'h00;
	localparam logic [31:0] KPI_RDZERO = 32'h0000_0000;
	localparam logic [1:0] KPI_SYNC_INIT = 2'h3;
endpackage

// [src/kpi_keypad_pin_interrupt.sv]
// eight-input pin interrupt detector with an avalon-mm register slave
//
// What this block does
// - control bit 3 reads the detect flag; writing bit 3 does not change it
// - control bit 2 is write-only acknowledge, always reads 0
// - control bit 1 gates the interrupt request to the cpu
// - control bit 0 selects edge-only or edge-and-level detection
// - each pin enable bit includes or excludes one input
// - polarity bit 0 means falling/low active, 1 rising/high active
// - enabled pull is pull-up at polarity 0, pull-down at polarity 1
// - an edge counts only after the input was seen deasserted
// - falling edge: sampled 1 then 0 in consecutive cycles
// - rising edge: sampled 0 then 1 in consecutive cycles
// - edge-only mode: a valid edge sets the flag; irq if enabled
// - edge-only mode: writing acknowledge 1 clears the flag
// - edge-and-level mode: edge or asserted level sets the flag
// - edge-and-level: acknowledge clears only if all enabled deasserted
// - seven registers: 4-bit control; 8-bit pin enable, polarity select, pull enable; 2-bit status, clear, enable
// - after deep stop wake-up the unit comes up in reset state
`timescale 1ns/1ps
module kpi_keypad_pin_interrupt
	import kpi_pkg::*;
#(
	parameter int NPIN = 8
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// avalon-mm slave
	input wire logic [3:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// pins
	input wire logic [NPIN-1:0] i_pin,
	output logic [NPIN-1:0] o_pull_en,
	output logic [NPIN-1:0] o_pull_up,
	output logic [NPIN-1:0] o_pull_down,
	// interrupts
	output logic o_cpu_irq,
	output logic o_irq
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [NPIN-1:0] s1;
		logic [NPIN-1:0] s2;
		logic [NPIN-1:0] s3;
		logic [NPIN-1:0] armed;
		logic mode;
		logic ie;
		logic flag;
		logic [NPIN-1:0] pe;
		logic [NPIN-1:0] es;
		logic [NPIN-1:0] pull;
		logic [KPI_NEV-1:0] ist;
		logic [KPI_NEV-1:0] ien;
		logic ack;
		logic [31:0] rdata;
		logic done;
		logic wreq;
		logic [NPIN-1:0] pen;
		logic [NPIN-1:0] pup;
		logic [NPIN-1:0] pdn;
		logic cirq;
		logic irq;
	} kpi_state_t;

	kpi_state_t r;
	kpi_state_t next_r;

	function automatic logic [7:0] kpi_lane0(input logic [31:0] d,
		input logic [7:0] old, input logic [3:0] be);
		kpi_lane0 = be[0] ? d[7:0] : old;
	endfunction

	logic [NPIN-1:0] level_act;
	logic [NPIN-1:0] edge_hit;
	logic any_asserted;
	logic wr_sc;
	logic ack_req;
	logic [KPI_NEV-1:0] ev;
	logic bus_req;
	logic wr_go;
	logic rd_go;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_r = r;
		// stable sample: second and third stage agree
		next_r.s1 = i_pin;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		// bus handshake: one wait state, then accept with waitrequest low
		bus_req = i_read || i_write;
		next_r.done = bus_req && !r.done;
		next_r.wreq = !(bus_req && !r.done);
		// writes land only at the edge where waitrequest is seen low
		wr_go = i_write && r.done;
		// read data is fetched in the wait cycle, shown in the accept cycle
		rd_go = i_read && !r.done;
		// asserted level of each input, per its polarity
		level_act = (r.s2 & r.s3 & r.es) | (~r.s2 & ~r.s3 & ~r.es);
		// arm once seen deasserted; edge when armed and now asserted
		edge_hit = r.armed & level_act & r.pe;
		for (int i = 0; i < NPIN; i++) begin
			if (!r.pe[i]) begin
				next_r.armed[i] = 1'b0;
			end else if (!level_act[i]) begin
				next_r.armed[i] = 1'b1;
			end else begin
				next_r.armed[i] = 1'b0;
			end
		end
		any_asserted = |(level_act & r.pe);
		wr_sc = wr_go && i_address == KPI_IDX_SC && i_byteenable[0];
		ack_req = wr_sc && i_writedata[KPI_SC_ACK];
		ev = '0;
		// flag: set wins over clear
		if (ack_req && (!r.mode || !any_asserted)) begin
			next_r.flag = 1'b0;
		end
		if (ack_req && r.mode && any_asserted) begin
			ev[KPI_EV_ACKFAIL] = 1'b1;
		end
		if ((|edge_hit) || (r.mode && any_asserted)) begin
			next_r.flag = 1'b1;
			ev[KPI_EV_DETECT] = !r.flag;
		end
		next_r.ack = ack_req;
		// register writes
		if (wr_go) begin
			case (i_address)
				KPI_IDX_SC: begin
					if (i_byteenable[0]) begin
						next_r.mode = i_writedata[KPI_SC_MODE];
						next_r.ie = i_writedata[KPI_SC_IE];
					end
				end
				KPI_IDX_PE: next_r.pe = kpi_lane0(i_writedata, r.pe,
					i_byteenable);
				KPI_IDX_ES: next_r.es = kpi_lane0(i_writedata, r.es,
					i_byteenable);
				KPI_IDX_PULL: next_r.pull = kpi_lane0(i_writedata, r.pull,
					i_byteenable);
				KPI_IDX_ICLR: begin
					if (i_byteenable[0]) begin
						next_r.ist = r.ist & ~i_writedata[KPI_NEV-1:0];
					end
				end
				KPI_IDX_IEN: begin
					if (i_byteenable[0]) begin
						next_r.ien = i_writedata[KPI_NEV-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		next_r.ist = next_r.ist | ev; // set wins over clear
		// read data
		next_r.rdata = KPI_RDZERO;
		if (rd_go) begin
			case (i_address)
				KPI_IDX_SC: begin
					next_r.rdata[KPI_SC_FLAG] = r.flag;
					next_r.rdata[KPI_SC_IE] = r.ie;
					next_r.rdata[KPI_SC_MODE] = r.mode; // ack reads 0
				end
				KPI_IDX_PE: next_r.rdata[NPIN-1:0] = r.pe;
				KPI_IDX_ES: next_r.rdata[NPIN-1:0] = r.es;
				KPI_IDX_PULL: next_r.rdata[NPIN-1:0] = r.pull;
				KPI_IDX_IST: next_r.rdata[KPI_NEV-1:0] = r.ist;
				KPI_IDX_IEN: next_r.rdata[KPI_NEV-1:0] = r.ien;
				default: next_r.rdata = KPI_RDZERO;
			endcase
		end
		next_r.pen = r.pull;
		next_r.pup = r.pull & ~r.es;
		next_r.pdn = r.pull & r.es;
		next_r.cirq = next_r.flag & next_r.ie;
		next_r.irq = |(next_r.ist & next_r.ien);
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			// idle waitrequest is high so no request is taken unanswered
			r <= '{wreq: 1'b1, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign o_readdata = r.rdata;
	assign o_waitrequest = r.wreq;
	assign o_pull_en = r.pen;
	assign o_pull_up = r.pup;
	assign o_pull_down = r.pdn;
	assign o_cpu_irq = r.cirq;
	assign o_irq = r.irq;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	property p_irq_level;
		o_cpu_irq == $past(next_r.flag & next_r.ie);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("cpu irq not flag and enable");

	property p_irq_gate;
		!r.ie && !(wr_sc && i_writedata[KPI_SC_IE]) |=> !o_cpu_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq issued while disabled");

	property p_ack_reads0;
		rd_go && i_address == KPI_IDX_SC |=> !o_readdata[KPI_SC_ACK];
	endproperty
	a_ack_reads0: assert property (p_ack_reads0)
		else $error("acknowledge bit read as one");

	property p_flag_read;
		rd_go && i_address == KPI_IDX_SC |=>
			o_readdata[KPI_SC_FLAG] == $past(r.flag);
	endproperty
	a_flag_read: assert property (p_flag_read)
		else $error("flag read wrong");

	sequence s_ack_clean;
		!r.mode && ack_req && !(|edge_hit);
	endsequence
	property p_edge_ack;
		s_ack_clean |=> !r.flag;
	endproperty
	a_edge_ack: assert property (p_edge_ack)
		else $error("edge mode ack did not clear");

	property p_level_hold;
		r.mode && r.flag && any_asserted |=> r.flag;
	endproperty
	a_level_hold: assert property (p_level_hold)
		else $error("flag cleared while input asserted");

	property p_edge_sets;
		(|edge_hit) |=> r.flag;
	endproperty
	a_edge_sets: assert property (p_edge_sets)
		else $error("edge did not set flag");

	property p_disabled_pin;
		r.pe == '0 && !r.mode |-> edge_hit == '0;
	endproperty
	a_disabled_pin: assert property (p_disabled_pin)
		else $error("disabled pin detected");

	property p_pull_sense;
		o_pull_up == (r.pen & ~$past(r.es)) || $changed(r.es);
	endproperty
	a_pull_sense: assert property (p_pull_sense)
		else $error("pull direction wrong");

	property p_flag_write;
		wr_sc && !i_writedata[KPI_SC_ACK] && r.flag |=> r.flag;
	endproperty
	a_flag_write: assert property (p_flag_write)
		else $error("write changed flag");

	property p_pull_down_sense;
		o_pull_down == (r.pen & $past(r.es));
	endproperty
	a_pull_down_sense: assert property (p_pull_down_sense)
		else $error("pull-down direction wrong");

	property p_ack_refused;
		ack_req && r.mode && any_asserted |=> r.ist[KPI_EV_ACKFAIL];
	endproperty
	a_ack_refused: assert property (p_ack_refused)
		else $error("refused acknowledge not recorded");

	property p_level_sets;
		r.mode && any_asserted |=> r.flag;
	endproperty
	a_level_sets: assert property (p_level_sets)
		else $error("asserted level did not set flag");

	property p_detect_event;
		(|edge_hit) && !r.flag |=> r.ist[KPI_EV_DETECT];
	endproperty
	a_detect_event: assert property (p_detect_event)
		else $error("detect event not recorded");

	property p_disarm_disabled;
		1'b1 |=> (r.armed & ~$past(r.pe)) == '0;
	endproperty
	a_disarm_disabled: assert property (p_disarm_disabled)
		else $error("disabled pin stays armed");

	property p_disarm_after_edge;
		(|edge_hit) |=> (r.armed & $past(edge_hit)) == '0;
	endproperty
	a_disarm_after_edge: assert property (p_disarm_after_edge)
		else $error("pin still armed after its edge");

	property p_pe_write;
		wr_go && i_address == KPI_IDX_PE && i_byteenable[0] |=>
			r.pe == $past(i_writedata[NPIN-1:0]);
	endproperty
	a_pe_write: assert property (p_pe_write)
		else $error("pin enable write lost");

	property p_es_write;
		wr_go && i_address == KPI_IDX_ES && i_byteenable[0] |=>
			r.es == $past(i_writedata[NPIN-1:0]);
	endproperty
	a_es_write: assert property (p_es_write)
		else $error("polarity write lost");

	property p_mode_write;
		wr_sc |=> r.mode == $past(i_writedata[KPI_SC_MODE]);
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("mode write lost");

	property p_ie_write;
		wr_sc |=> r.ie == $past(i_writedata[KPI_SC_IE]);
	endproperty
	a_ie_write: assert property (p_ie_write)
		else $error("interrupt enable write lost");

	property p_irq_status;
		o_irq == $past(|(next_r.ist & next_r.ien));
	endproperty
	a_irq_status: assert property (p_irq_status)
		else $error("status interrupt not status and enable");

	// ****************************************
	// bus handshake assertions
	// ****************************************
	sequence s_req_wait;
		bus_req && o_waitrequest;
	endsequence
	property p_one_wait;
		s_req_wait ##1 bus_req |-> !o_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("request not accepted after one wait state");

	property p_wait_idle;
		!bus_req |=> o_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle)
		else $error("waitrequest low with no request");

	property p_rdata_idle;
		!rd_go |=> o_readdata == KPI_RDZERO;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data shown outside a read");
endmodule

// [dv/kpi_keypad_model.sv]
// keypad model: switches drive pins, pulls hold released pins
`timescale 1ns/1ps
module kpi_keypad_model (
	// clock
	input wire logic i_core_clk,
	// switches and pulls
	input wire logic [7:0] i_press,
	input wire logic [7:0] i_level,
	input wire logic [7:0] i_pull_up,
	input wire logic [7:0] i_pull_down,
	// pins
	output logic [7:0] o_pin
);
	logic [7:0] wobble = 8'h55;
	// open pins with no pull float: show a changing pattern
	always @(posedge i_core_clk) wobble <= ~wobble;
	assign o_pin = (i_press & i_level)
		| (~i_press & (i_pull_up | (~i_pull_down & wobble)));
endmodule

// [dv/kpi_keypad_pin_interrupt_tb.sv]
// self-checking bench for the keypad pin interrupt
`timescale 1ns/1ps
module kpi_keypad_pin_interrupt_tb;
	import kpi_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wreq, cpu_irq, irq;
	logic [7:0] pin, pen, pup, pdn;
	logic [7:0] press = 8'h00;
	int failures = 0;
	int n_checks = 0;
	// ****************************************
	// design and keypad
	// ****************************************
	kpi_keypad_pin_interrupt u_kpi_keypad_pin_interrupt (
		.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_address(adr),
		.i_read(rd_en), .i_write(wr_en), .i_writedata(wdat),
		.i_byteenable(4'hF), .o_readdata(rdat), .o_waitrequest(wreq),
		.i_pin(pin), .o_pull_en(pen), .o_pull_up(pup),
		.o_pull_down(pdn), .o_cpu_irq(cpu_irq), .o_irq(irq));
	kpi_keypad_model u_kpi_keypad_model (.i_core_clk(i_core_clk),
		.i_press(press), .i_level(8'h0F), .i_pull_up(pup),
		.i_pull_down(pdn), .o_pin(pin));
	initial begin
		forever #50 i_core_clk = ~i_core_clk;
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		adr <= a;
		wdat <= {24'h0, d};
		wr_en <= 1'b1;
		do @(posedge i_core_clk); while (wreq !== 1'b0);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		logic [31:0] got;
		@(posedge i_core_clk);
		adr <= a;
		rd_en <= 1'b1;
		do @(posedge i_core_clk); while (wreq !== 1'b0);
		// read data taken at the edge where waitrequest is seen low
		got = rdat;
		rd_en <= 1'b0;
		chk($sformatf("reg %h", a), got, {24'h0, exp});
	endtask
	// set switches, let the three-flop sync settle, check the request
	task automatic pins(input logic [7:0] p, input logic e);
		@(posedge i_core_clk);
		press <= p;
		repeat (8) @(negedge i_core_clk);
		chk("cpu_irq", {31'h0, cpu_irq}, {31'h0, e});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		rd(KPI_IDX_SC, 8'h00);
		rd(KPI_IDX_PE, 8'h00);
		rd(KPI_IDX_ES, 8'h00);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		wr(KPI_IDX_SC, 8'h00);
		wr(KPI_IDX_ES, 8'h0F);
		wr(KPI_IDX_PULL, 8'hFF);
		wr(KPI_IDX_PE, 8'hFF);
		wr(KPI_IDX_SC, 8'h04);
		wr(KPI_IDX_SC, 8'h02);
		chk("pull_up", {24'h0, pup}, 32'h0000_00F0);
		chk("pull_down", {24'h0, pdn}, 32'h0000_000F);
		rd(KPI_IDX_SC, 8'h02);
		for (int n = 0; n < 8; n++) begin
			pins(8'h01 << n, 1'b1);
			rd(KPI_IDX_SC, 8'h0A);
			wr(KPI_IDX_SC, 8'h06);
			rd(KPI_IDX_SC, 8'h02);
			pins(8'h00, 1'b0);
		end
		wr(KPI_IDX_SC, 8'h0A);
		rd(KPI_IDX_SC, 8'h02);
		wr(KPI_IDX_PE, 8'h01);
		pins(8'h02, 1'b0);
		wr(KPI_IDX_PE, 8'h03);
		pins(8'h02, 1'b0);
		pins(8'h00, 1'b0);
		pins(8'h02, 1'b1);
		wr(KPI_IDX_SC, 8'h04);
		pins(8'h01, 1'b0);
		rd(KPI_IDX_SC, 8'h08);
		wr(KPI_IDX_PE, 8'h00);
		wr(KPI_IDX_SC, 8'h07);
		rd(KPI_IDX_SC, 8'h03);
		wr(KPI_IDX_PE, 8'h01);
		pins(8'h01, 1'b1);
		wr(KPI_IDX_SC, 8'h07);
		rd(KPI_IDX_SC, 8'h0B);
		rd(KPI_IDX_IST, 8'h03);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(KPI_IDX_IEN, 8'h02);
		rd(KPI_IDX_IEN, 8'h02);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(KPI_IDX_ICLR, 8'h03);
		rd(KPI_IDX_IST, 8'h00);
		chk("irq", {31'h0, irq}, 32'h0);
		pins(8'h00, 1'b1);
		wr(KPI_IDX_SC, 8'h07);
		rd(KPI_IDX_SC, 8'h03);
		pins(8'h00, 1'b0);
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge i_core_clk);
		failures++;
		tally_and_finish();
	end
endmodule
